// *** rtl/mcs_pkg.sv ***
package mcs_pkg;
	localparam int SMP_W = 16;
	localparam int ACC_W = 24;
	localparam int TACC_W = 26;
	localparam int CNT_W = 8;
	localparam int WAKE_W = 12;
	localparam int TMO_W = 24;
	localparam int CAL_SHIFT = 12;

	localparam logic [7:0] GC_ADDR = 8'h00;
	localparam logic [7:0] GC_RESET_CMD = 8'h06;

	localparam logic [2:0] MODE_PDOWN = 3'h0;
	localparam logic [2:0] MODE_SHUNT_TRIG = 3'h1;
	localparam logic [2:0] MODE_BUS_TRIG = 3'h2;
	localparam logic [2:0] MODE_BOTH_TRIG = 3'h3;
	localparam logic [2:0] MODE_ADC_OFF = 3'h4;
	localparam logic [2:0] MODE_SHUNT_CONT = 3'h5;
	localparam logic [2:0] MODE_BUS_CONT = 3'h6;
	localparam logic [2:0] MODE_BOTH_CONT = 3'h7;
	localparam int MODE_SHUNT_BIT = 0;
	localparam int MODE_BUS_BIT = 1;
	localparam int MODE_CONT_BIT = 2;

	localparam int STAT_CVR_BIT = 6;
	localparam int STAT_CRT_BIT = 5;

	localparam int CLK_PERIOD_NS = 10;
	localparam int PDOWN_RECOVERY_US = 40;
	localparam int WAKE_CYCLES = (PDOWN_RECOVERY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TEMP_MAX_MS = 130;
	localparam int TEMP_MAX_CYCLES = (TEMP_MAX_MS * 1000000) / CLK_PERIOD_NS;
	localparam int TEMP_READINGS = 4;
	localparam int TEMP_SAMPLES_PER_READING = 150;
	localparam int SHUNT_FS_MAX_MV = 320;

	typedef enum logic [1:0] {CH_SHUNT, CH_BUS, CH_TEMP} mcs_chan_e;
	typedef enum logic [2:0] {ST_IDLE, ST_WAKE, ST_SHUNT, ST_BUS, ST_TEMP} mcs_state_e;

	typedef struct packed {
		logic [2:0] mode;
		logic [2:0] shunt_average_count;
		logic [2:0] bus_average_count;
		logic [1:0] pga;
		logic bus_32v;
		logic temp_en;
	} mcs_cfg_s;

	typedef struct packed {
		logic start;
		mcs_chan_e chan;
		logic [1:0] temp_phase;
		logic [1:0] gain;
	} mcs_adc_req_s;

	typedef struct packed {
		logic [7:0] status_mask;
		logic alert_en;
		logic wd_active_high;
		logic wd_latched;
	} mcs_wd_s;

	typedef struct packed {
		mcs_state_e state;
		logic [CNT_W-1:0] cnt;
		logic [1:0] ph;
		logic signed [ACC_W-1:0] acc;
		logic signed [TACC_W-1:0] tacc;
		logic waiting;
		logic [WAKE_W-1:0] wake;
		logic [TMO_W-1:0] tmo;
		logic pd;
		logic pend;
		logic ovr;
		logic signed [SMP_W-1:0] shres;
		logic signed [SMP_W-1:0] bsres;
		logic signed [TACC_W-1:0] tres;
		mcs_adc_req_s req;
		logic abort;
		logic mgo;
		logic mvolt;
		logic mtemp;
	} mcs_seq_s;

	typedef struct packed {
		logic [1:0] stage;
		logic signed [SMP_W-1:0] sh;
		logic signed [SMP_W-1:0] bs;
		logic signed [SMP_W-1:0] cur;
		logic signed [2*SMP_W-1:0] pwr;
		logic volt;
		logic temp;
		logic conv_ready_flag;
		logic temp_conv_ready_flag;
	} mcs_math_s;

	localparam mcs_seq_s SEQ_RESET = '0;
	localparam mcs_math_s MATH_RESET = '0;
	localparam mcs_wd_s WD_RESET = '{status_mask: 8'hff, alert_en: 1'b0, wd_active_high: 1'b0, wd_latched: 1'b0};
endpackage

// *** rtl/mcs_sequencer.sv ***
`timescale 1ns/100ps
module mcs_sequencer #(
	parameter int TEMP_TIMEOUT_CYCLES = mcs_pkg::TEMP_MAX_CYCLES
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic rx_start,
	input wire logic rx_byte_valid,
	input wire logic [7:0] rx_byte,
	output logic gc_ack,
	output logic soft_reset,
	input wire mcs_pkg::mcs_cfg_s cfg,
	input wire logic [15:0] cal_value,
	input wire logic one_shot_trigger,
	input wire logic status_read,
	input wire logic wd_write,
	input wire mcs_pkg::mcs_wd_s wd_wdata,
	output mcs_pkg::mcs_wd_s wd_cfg,
	output mcs_pkg::mcs_adc_req_s adc_req,
	output logic adc_abort,
	input wire logic adc_done,
	input wire logic signed [15:0] adc_data,
	output logic signed [15:0] shunt_result,
	output logic signed [15:0] bus_result,
	output logic signed [15:0] current_result,
	output logic signed [31:0] power_result,
	output logic signed [25:0] temp_result,
	output logic temp_overrun,
	output logic [7:0] status,
	output logic busy
);
	import mcs_pkg::*;

	if (TEMP_TIMEOUT_CYCLES < 1 || TEMP_TIMEOUT_CYCLES >= (1 << TMO_W)) begin : g_chk_tmo
		$error("TEMP_TIMEOUT_CYCLES out of range");
	end

	function automatic logic signed [SMP_W-1:0] avg_div(input logic signed [ACC_W-1:0] s, input logic [2:0] n);
		logic signed [ACC_W-1:0] t;
		t = s >>> n;
		return t[SMP_W-1:0];
	endfunction

	function automatic logic [CNT_W-1:0] avg_last(input logic [2:0] n);
		logic [CNT_W-1:0] one;
		one = CNT_W'(1);
		return (one << n) - one;
	endfunction

	// General-call decoder
	logic first_r, first_nxt;
	logic armed_r, armed_nxt;
	logic ack_r, ack_nxt;
	logic sw_rst_r, sw_rst_nxt;

	always_comb begin
		first_nxt = first_r;
		armed_nxt = armed_r;
		ack_nxt = 1'b0;
		sw_rst_nxt = 1'b0;
		if (rx_start) begin
			first_nxt = 1'b1;
			armed_nxt = 1'b0;
		end else if (rx_byte_valid) begin
			first_nxt = 1'b0;
			armed_nxt = 1'b0;
			if (first_r && rx_byte == GC_ADDR) begin
				ack_nxt = 1'b1;
				armed_nxt = 1'b1;
			end else if (armed_r && rx_byte == GC_RESET_CMD) begin
				sw_rst_nxt = 1'b1;
			end
			// Any other command byte just disarms the decoder
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			first_r <= 1'b0;
			armed_r <= 1'b0;
			ack_r <= 1'b0;
			sw_rst_r <= 1'b0;
		end else begin
			first_r <= first_nxt;
			armed_r <= armed_nxt;
			ack_r <= ack_nxt;
			sw_rst_r <= sw_rst_nxt;
		end
	end

	// Conversion sequencer
	mcs_seq_s seq_r, seq_nxt;
	logic mode_off;
	logic volt_done;
	logic signed [ACC_W-1:0] acc_sum;
	logic signed [TACC_W-1:0] tacc_sum;

	assign mode_off = cfg.mode[MODE_SHUNT_BIT] == 1'b0 && cfg.mode[MODE_BUS_BIT] == 1'b0;
	assign acc_sum = seq_r.acc + ACC_W'(adc_data);
	assign tacc_sum = seq_r.tacc + TACC_W'(adc_data);

	always_comb begin
		seq_nxt = seq_r;
		seq_nxt.req.start = 1'b0;
		seq_nxt.abort = 1'b0;
		seq_nxt.mgo = 1'b0;
		seq_nxt.mvolt = 1'b0;
		seq_nxt.mtemp = 1'b0;
		volt_done = 1'b0;
		if (cfg.mode == MODE_PDOWN) begin
			seq_nxt.pd = 1'b1;
		end
		case (seq_r.state)
			ST_IDLE: begin
				if (!mode_off) begin
					if (seq_r.pd) begin
						seq_nxt.state = ST_WAKE;
						seq_nxt.wake = '0;
					end else if (cfg.mode[MODE_CONT_BIT] || seq_r.pend) begin
						seq_nxt.pend = 1'b0;
						seq_nxt.cnt = '0;
						seq_nxt.acc = '0;
						seq_nxt.waiting = 1'b0;
						seq_nxt.state = cfg.mode[MODE_SHUNT_BIT] ? ST_SHUNT : ST_BUS;
					end
				end
			end
			ST_WAKE: begin
				// Front end settles before any sample is trusted
				if (seq_r.wake == WAKE_W'(WAKE_CYCLES - 1)) begin
					seq_nxt.pd = 1'b0;
					seq_nxt.state = ST_IDLE;
				end else begin
					seq_nxt.wake = seq_r.wake + WAKE_W'(1);
				end
			end
			ST_SHUNT: begin
				if (!seq_r.waiting) begin
					seq_nxt.req.start = 1'b1;
					seq_nxt.req.chan = CH_SHUNT;
					seq_nxt.req.temp_phase = '0;
					seq_nxt.req.gain = cfg.pga;
					seq_nxt.waiting = 1'b1;
				end else if (adc_done) begin
					seq_nxt.waiting = 1'b0;
					// >= so a shrunk count mid-run still terminates
					if (seq_r.cnt >= avg_last(cfg.shunt_average_count)) begin
						seq_nxt.shres = avg_div(acc_sum, cfg.shunt_average_count);
						seq_nxt.cnt = '0;
						seq_nxt.acc = '0;
						if (cfg.mode[MODE_BUS_BIT]) begin
							seq_nxt.state = ST_BUS;
						end else begin
							volt_done = 1'b1;
						end
					end else begin
						seq_nxt.acc = acc_sum;
						seq_nxt.cnt = seq_r.cnt + CNT_W'(1);
					end
				end
			end
			ST_BUS: begin
				if (!seq_r.waiting) begin
					seq_nxt.req.start = 1'b1;
					seq_nxt.req.chan = CH_BUS;
					seq_nxt.req.temp_phase = '0;
					seq_nxt.req.gain = {1'b0, cfg.bus_32v};
					seq_nxt.waiting = 1'b1;
				end else if (adc_done) begin
					seq_nxt.waiting = 1'b0;
					if (seq_r.cnt >= avg_last(cfg.bus_average_count)) begin
						seq_nxt.bsres = avg_div(acc_sum, cfg.bus_average_count);
						seq_nxt.cnt = '0;
						seq_nxt.acc = '0;
						volt_done = 1'b1;
					end else begin
						seq_nxt.acc = acc_sum;
						seq_nxt.cnt = seq_r.cnt + CNT_W'(1);
					end
				end
			end
			ST_TEMP: begin
				seq_nxt.tmo = seq_r.tmo + TMO_W'(1);
				if (seq_r.tmo == TMO_W'(TEMP_TIMEOUT_CYCLES - 1)) begin
					// Overlong reading is dropped; old result stays
					seq_nxt.ovr = 1'b1;
					seq_nxt.abort = seq_r.waiting;
					seq_nxt.waiting = 1'b0;
					seq_nxt.state = ST_IDLE;
					seq_nxt.mgo = 1'b1;
					seq_nxt.mvolt = 1'b1;
				end else if (!seq_r.waiting) begin
					seq_nxt.req.start = 1'b1;
					seq_nxt.req.chan = CH_TEMP;
					seq_nxt.req.temp_phase = seq_r.ph;
					seq_nxt.req.gain = '0;
					seq_nxt.waiting = 1'b1;
				end else if (adc_done) begin
					seq_nxt.waiting = 1'b0;
					seq_nxt.tacc = tacc_sum;
					if (seq_r.cnt == CNT_W'(TEMP_SAMPLES_PER_READING - 1)) begin
						seq_nxt.cnt = '0;
						if (seq_r.ph == 2'(TEMP_READINGS - 1)) begin
							seq_nxt.tres = tacc_sum;
							seq_nxt.ovr = 1'b0;
							seq_nxt.state = ST_IDLE;
							seq_nxt.mgo = 1'b1;
							seq_nxt.mvolt = 1'b1;
							seq_nxt.mtemp = 1'b1;
						end else begin
							seq_nxt.ph = seq_r.ph + 2'(1);
						end
					end else begin
						seq_nxt.cnt = seq_r.cnt + CNT_W'(1);
					end
				end
			end
			default: begin
				seq_nxt.state = ST_IDLE;
			end
		endcase
		if (volt_done) begin
			if (cfg.temp_en) begin
				seq_nxt.state = ST_TEMP;
				seq_nxt.ph = '0;
				seq_nxt.tacc = '0;
				seq_nxt.tmo = '0;
			end else begin
				seq_nxt.state = ST_IDLE;
				seq_nxt.mgo = 1'b1;
				seq_nxt.mvolt = 1'b1;
			end
		end
		if (mode_off && seq_r.state != ST_IDLE) begin
			seq_nxt.state = ST_IDLE;
			seq_nxt.waiting = 1'b0;
			seq_nxt.req.start = 1'b0;
			seq_nxt.mgo = 1'b0;
			seq_nxt.abort = seq_r.waiting || seq_r.req.start;
		end
		// Trigger after the start check so none is lost
		if (one_shot_trigger && !cfg.mode[MODE_CONT_BIT] && !mode_off) begin
			seq_nxt.pend = 1'b1;
		end
		if (sw_rst_r) begin
			seq_nxt = SEQ_RESET;
			seq_nxt.abort = seq_r.state != ST_IDLE;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			seq_r <= SEQ_RESET;
		end else begin
			seq_r <= seq_nxt;
		end
	end

	// Background math and ready flags
	mcs_math_s m_r, m_nxt;
	logic signed [2*SMP_W:0] cur_prod;

	assign cur_prod = m_r.sh * $signed({1'b0, cal_value});

	always_comb begin
		m_nxt = m_r;
		if (status_read || one_shot_trigger) begin
			m_nxt.conv_ready_flag = 1'b0;
			m_nxt.temp_conv_ready_flag = 1'b0;
		end
		case (m_r.stage)
			2'd0: begin
				if (seq_r.mgo) begin
					// Pair from one cycle, even if sampled far apart
					m_nxt.sh = seq_r.shres;
					m_nxt.bs = seq_r.bsres;
					m_nxt.volt = seq_r.mvolt;
					m_nxt.temp = seq_r.mtemp;
					m_nxt.stage = 2'd1;
				end
			end
			2'd1: begin
				m_nxt.cur = cur_prod[CAL_SHIFT+SMP_W-1:CAL_SHIFT];
				m_nxt.stage = 2'd2;
			end
			2'd2: begin
				m_nxt.pwr = m_r.cur * m_r.bs;
				m_nxt.stage = 2'd0;
				// Set after the clear: a clear in the same cycle loses
				if (m_r.volt) begin
					m_nxt.conv_ready_flag = 1'b1;
				end
				if (m_r.temp) begin
					m_nxt.temp_conv_ready_flag = 1'b1;
				end
			end
			default: begin
				m_nxt.stage = 2'd0;
			end
		endcase
		if (sw_rst_r) begin
			m_nxt = MATH_RESET;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			m_r <= MATH_RESET;
		end else begin
			m_r <= m_nxt;
		end
	end

	// Alert and watchdog configuration defaults
	mcs_wd_s wd_r, wd_nxt;

	always_comb begin
		wd_nxt = wd_r;
		if (wd_write) begin
			wd_nxt = wd_wdata;
		end
		if (sw_rst_r) begin
			wd_nxt = WD_RESET;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wd_r <= WD_RESET;
		end else begin
			wd_r <= wd_nxt;
		end
	end

	logic [7:0] status_r, status_nxt;
	logic busy_r, busy_nxt;

	always_comb begin
		status_nxt = '0;
		status_nxt[STAT_CVR_BIT] = m_nxt.conv_ready_flag;
		status_nxt[STAT_CRT_BIT] = m_nxt.temp_conv_ready_flag;
		busy_nxt = seq_nxt.state != ST_IDLE;
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			status_r <= '0;
			busy_r <= 1'b0;
		end else begin
			status_r <= status_nxt;
			busy_r <= busy_nxt;
		end
	end

	assign gc_ack = ack_r;
	assign soft_reset = sw_rst_r;
	assign wd_cfg = wd_r;
	assign adc_req = seq_r.req;
	assign adc_abort = seq_r.abort;
	assign shunt_result = seq_r.shres;
	assign bus_result = seq_r.bsres;
	assign temp_result = seq_r.tres;
	assign temp_overrun = seq_r.ovr;
	assign current_result = m_r.cur;
	assign power_result = m_r.pwr;
	assign status = status_r;
	assign busy = busy_r;
endmodule

// *** testbench/mcs_adc_model.sv ***
`timescale 1ns/100ps
module mcs_adc_model (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire mcs_pkg::mcs_adc_req_s adc_req,
	input wire logic adc_abort,
	input wire logic [3:0] lat,
	output logic adc_done,
	output logic signed [15:0] adc_data
);
	import mcs_pkg::*;
	logic [3:0] wait_r;
	logic pend_r;
	mcs_chan_e chan_r;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pend_r <= 1'b0;
			wait_r <= 4'h0;
			chan_r <= CH_SHUNT;
			adc_done <= 1'b0;
			adc_data <= 16'h0000;
		end else begin
			adc_done <= 1'b0;
			// Idle data toggles so a stale word read one cycle after adc_done never passes for a sample
			adc_data <= ~adc_data;
			if (adc_abort) begin
				pend_r <= 1'b0;
			end else if (adc_req.start) begin
				pend_r <= 1'b1;
				wait_r <= lat;
				chan_r <= adc_req.chan;
			end else if (pend_r && wait_r != 4'h0) begin
				wait_r <= wait_r - 4'h1;
			end else if (pend_r) begin
				pend_r <= 1'b0;
				adc_done <= 1'b1;
				adc_data <= (chan_r == CH_SHUNT) ? 16'h0100 : (chan_r == CH_BUS) ? 16'h0200 : 16'h0010;
			end
		end
	end
endmodule

// *** testbench/mcs_sequencer_checker.sv ***
`timescale 1ns/100ps
module mcs_sequencer_checker (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic rx_start,
	input wire logic rx_byte_valid,
	input wire logic [7:0] rx_byte,
	input wire logic gc_ack,
	input wire logic soft_reset,
	input wire mcs_pkg::mcs_cfg_s cfg,
	input wire logic one_shot_trigger,
	input wire logic status_read,
	input wire mcs_pkg::mcs_wd_s wd_cfg,
	input wire mcs_pkg::mcs_adc_req_s adc_req,
	input wire logic adc_done,
	input wire logic [7:0] status,
	input wire logic busy
);
	import mcs_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	a_gc_addr_ack: assert property (rx_start ##1 (rx_byte_valid && rx_byte == GC_ADDR) |=> gc_ack)
		else $error("general call not acknowledged");
	a_gc_reset_cmd: assert property (gc_ack ##1 (rx_byte_valid && rx_byte == GC_RESET_CMD) |=> soft_reset)
		else $error("reset command not executed");
	a_gc_other_cmd: assert property (gc_ack ##1 (rx_byte_valid && rx_byte != GC_RESET_CMD) |=> !soft_reset)
		else $error("other command acted on");
	a_reset_state: assert property (soft_reset |=> status == 8'h00 && !busy && wd_cfg == WD_RESET)
		else $error("state not at reset values");
	a_off_no_start: assert property ((cfg.mode[1:0] == 2'b00) [*3] |-> !adc_req.start)
		else $error("sample started while halted");
	// Quiet history keeps a same-cycle flag set out of the antecedent
	a_flag_clear: assert property (!busy [*5] ##0 (status_read || one_shot_trigger) |=> status == 8'h00)
		else $error("flags not cleared");
	a_flag_time: assert property ($rose(status[STAT_CVR_BIT]) || $rose(status[STAT_CRT_BIT]) |-> $past(adc_done, 4))
		else $error("flag set off the end of sequence");
	a_req_gain: assert property (adc_req.start |-> adc_req.gain ==
		(adc_req.chan == CH_SHUNT ? cfg.pga : {1'b0, cfg.bus_32v & (adc_req.chan == CH_BUS)}))
		else $error("wrong converter gain");
endmodule

bind mcs_sequencer mcs_sequencer_checker u_chk (.sys_clk(sys_clk), .reset_n(reset_n), .rx_start(rx_start),
	.rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .gc_ack(gc_ack), .soft_reset(soft_reset), .cfg(cfg),
	.one_shot_trigger(one_shot_trigger), .status_read(status_read), .wd_cfg(wd_cfg), .adc_req(adc_req),
	.adc_done(adc_done), .status(status), .busy(busy));

// *** testbench/tb.sv ***
`timescale 1ns/100ps
module tb;
	import mcs_pkg::*;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic rx_start = 1'b0;
	logic rx_byte_valid = 1'b0;
	logic [7:0] rx_byte = 8'h00;
	mcs_cfg_s cfg = '{mode: MODE_ADC_OFF, default: '0};
	logic one_shot_trigger = 1'b0;
	logic status_read = 1'b0;
	logic wd_write = 1'b0;
	mcs_wd_s wd_wdata = '0;
	logic [3:0] lat = 4'h1;
	logic gc_ack, soft_reset, adc_abort, adc_done, busy, temp_overrun;
	mcs_wd_s wd_cfg;
	mcs_adc_req_s adc_req;
	logic signed [15:0] adc_data, shunt_result, bus_result, current_result;
	logic signed [31:0] power_result;
	logic signed [25:0] temp_result;
	logic [7:0] status;
	int n_sh, n_bs, n_tp, n_gc, n_sr, n_ab;
	int fail_count = 0;
	int check_count = 0;

	always #5 sys_clk = ~sys_clk;

	// Unity calibration, so current equals shunt
	mcs_sequencer #(.TEMP_TIMEOUT_CYCLES(20000)) u_mcs_sequencer (.sys_clk(sys_clk), .reset_n(reset_n),
		.rx_start(rx_start), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .gc_ack(gc_ack),
		.soft_reset(soft_reset), .cfg(cfg), .cal_value(16'h1000), .one_shot_trigger(one_shot_trigger),
		.status_read(status_read), .wd_write(wd_write), .wd_wdata(wd_wdata), .wd_cfg(wd_cfg), .adc_req(adc_req),
		.adc_abort(adc_abort), .adc_done(adc_done), .adc_data(adc_data), .shunt_result(shunt_result),
		.bus_result(bus_result), .current_result(current_result), .power_result(power_result),
		.temp_result(temp_result), .temp_overrun(temp_overrun), .status(status), .busy(busy));
	mcs_adc_model u_mcs_adc_model (.sys_clk(sys_clk), .reset_n(reset_n), .adc_req(adc_req),
		.adc_abort(adc_abort), .lat(lat), .adc_done(adc_done), .adc_data(adc_data));

	always @(posedge sys_clk) begin
		n_sh += int'(adc_req.start && adc_req.chan == CH_SHUNT);
		n_bs += int'(adc_req.start && adc_req.chan == CH_BUS);
		n_tp += int'(adc_req.start && adc_req.chan == CH_TEMP);
		n_gc += int'(gc_ack);
		n_sr += int'(soft_reset);
		n_ab += int'(adc_abort);
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask

	task automatic give_verdict();
		$display("Checks: %0d, mismatches: %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic pulse(ref logic s);
		@(negedge sys_clk);
		s = 1'b1;
		@(negedge sys_clk);
		s = 1'b0;
	endtask

	task automatic send_gc(input logic [7:0] a, input logic [7:0] c);
		pulse(rx_start);
		rx_byte_valid = 1'b1;
		rx_byte = a;
		@(negedge sys_clk);
		rx_byte_valid = 1'b0;
		@(negedge sys_clk);
		rx_byte_valid = 1'b1;
		rx_byte = c;
		@(negedge sys_clk);
		rx_byte_valid = 1'b0;
		// Config register follows a cycle late, so any abort is the reset's own
		@(negedge sys_clk);
		if (c == GC_RESET_CMD && a == GC_ADDR) cfg.mode = MODE_ADC_OFF;
		repeat (2) @(negedge sys_clk);
	endtask

	task automatic t_reset();
		chk("wd reset", WD_RESET, wd_cfg);
		chk("status reset", 0, status);
	endtask

	task automatic t_trig();
		int s, b, p, n;
		cfg.shunt_average_count = 3'h1;
		cfg.bus_average_count = 3'h2;
		cfg.pga = 2'h2;
		cfg.bus_32v = 1'b1;
		for (int m = 1; m < 4; m++) begin
			cfg.mode = 3'(m);
			cfg.temp_en = (m == 3);
			lat = 4'(3 * m);
			s = n_sh;
			b = n_bs;
			p = n_tp;
			pulse(one_shot_trigger);
			chk("cleared by trigger", 0, status);
			n = 0;
			while (status !== (m == 3 ? 8'h60 : 8'h40) && n < 20000) begin
				@(negedge sys_clk);
				n++;
			end
			repeat (40) @(negedge sys_clk);
			chk("ready flags", m == 3 ? 8'h60 : 8'h40, status);
			chk("shunt samples", m[0] ? 2 : 0, n_sh - s);
			chk("bus samples", m[1] ? 4 : 0, n_bs - b);
			chk("temp samples", m == 3 ? 600 : 0, n_tp - p);
			chk("shunt held", 16'h0100, shunt_result);
		end
		chk("bus", 16'h0200, bus_result);
		chk("temp", 26'h2580, temp_result);
		chk("no overrun", 0, temp_overrun);
		chk("current", 16'h0100, current_result);
		chk("power", 32'h0002_0000, power_result);
		pulse(status_read);
		chk("cleared by read", 0, status);
	endtask

	task automatic t_cont();
		int s, b, n;
		cfg.shunt_average_count = 3'h2;
		cfg.bus_average_count = 3'h0;
		cfg.temp_en = 1'b0;
		lat = 4'h2;
		s = n_sh;
		b = n_bs;
		cfg.mode = MODE_BOTH_CONT;
		n = 0;
		while (n_bs == b && n < 500) begin
			@(negedge sys_clk);
			n++;
		end
		chk("shunt before bus", 4, n_sh - s);
		repeat (300) @(negedge sys_clk);
		chk("keeps converting", 1, n_bs - b > 3);
		cfg.mode = MODE_ADC_OFF;
		repeat (10) @(negedge sys_clk);
		s = n_sh + n_bs;
		repeat (200) @(negedge sys_clk);
		chk("halted", 0, n_sh + n_bs - s);
		chk("idle", 0, busy);
	endtask

	task automatic t_pdown();
		int s, b;
		cfg.shunt_average_count = 3'h0;
		cfg.bus_average_count = 3'h0;
		cfg.temp_en = 1'b0;
		lat = 4'h1;
		cfg.mode = MODE_PDOWN;
		repeat (10) @(negedge sys_clk);
		pulse(status_read);
		chk("idle in power-down", 0, busy);
		b = n_bs;
		cfg.mode = MODE_BUS_CONT;
		// Host holds off for the recovery time before trusting results
		repeat (WAKE_CYCLES - 10) @(negedge sys_clk);
		chk("no sample in wake", 0, n_bs - b);
		chk("no flag in wake", 0, status);
		repeat (100) @(negedge sys_clk);
		chk("bus after wake", 1, n_bs - b > 3);
		chk("flag after wake", 8'h40, status);
		cfg.mode = MODE_SHUNT_CONT;
		repeat (10) @(negedge sys_clk);
		s = n_sh;
		b = n_bs;
		repeat (100) @(negedge sys_clk);
		chk("shunt only", 1, n_sh - s > 3);
		chk("no bus", 0, n_bs - b);
		cfg.mode = MODE_ADC_OFF;
		repeat (10) @(negedge sys_clk);
	endtask

	task automatic t_gc();
		int g, r, a;
		wd_wdata = '{status_mask: 8'h00, alert_en: 1'b1, wd_active_high: 1'b1, wd_latched: 1'b1};
		pulse(wd_write);
		g = n_gc;
		r = n_sr;
		send_gc(8'h05, GC_RESET_CMD);
		chk("ack wrong address", 0, n_gc - g);
		send_gc(GC_ADDR, 8'h05);
		chk("ack", 1, n_gc - g);
		chk("other command", 0, n_sr - r);
		chk("wd kept", 11'h007, wd_cfg);
		lat = 4'hf;
		cfg.mode = MODE_BOTH_CONT;
		repeat (20) @(negedge sys_clk);
		a = n_ab;
		send_gc(GC_ADDR, GC_RESET_CMD);
		chk("soft reset", 1, n_sr - r);
		chk("abort", 1, n_ab - a);
		chk("wd defaults", WD_RESET, wd_cfg);
		chk("result reset", 0, shunt_result);
		chk("idle", 0, busy);
	endtask

	initial begin
		repeat (12) @(negedge sys_clk);
		reset_n = 1'b1;
		t_reset();
		t_trig();
		t_cont();
		t_pdown();
		t_gc();
		give_verdict();
	end

	initial begin
		#(50000 * 10);
		fail_count++;
		give_verdict();
	end
endmodule
